// *** hdl/qusmp_pkg.sv ***
// Shared constants and state types for the quad serial modem pin block
package qusmp_pkg;
  localparam int          NUM_CH       = 4;
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          FRAME_BITS   = 10;
  localparam logic [7:0]  BIT_CYC      = 8'h10;  // Clocks per serial bit
  localparam logic [7:0]  RX_HALF_CYC  = 8'h08;  // Start bit mid-sample point
  localparam logic [7:0]  IR_PULSE_CYC = 8'h03;  // Infrared pulse, 3/16 bit
  localparam logic [3:0]  STOP_IDX     = 4'h9;   // Frame index of stop bit
  localparam logic        TX_IDLE      = 1'b1;
  localparam logic        IR_IDLE      = 1'b0;
  localparam logic        PIN_OFF_N    = 1'b1;   // Deasserted active-low pin
  localparam logic [7:0]  STATUS_RST   = 8'h00;

  typedef struct packed {
    logic [1:0]  rxSync;
    logic [1:0]  ctsSync;
    logic [1:0]  dsrSync;
    logic [1:0]  cdSync;
    logic        txBusy;
    logic [9:0]  txShift;
    logic [3:0]  txBitCnt;
    logic [7:0]  txCyc;
    logic        serialOut;
    logic        irOut;
    logic        rxBusy;
    logic [7:0]  rxCyc;
    logic [3:0]  rxBitCnt;
    logic [7:0]  rxShift;
    logic [7:0]  rxHold;
    logic        rxDataReadyN;
    logic [7:0]  irStretch;
    logic        requestSendN;
    logic        terminalReadyN;
    logic        txSpaceReadyN;
  } qusmp_chan_s;

  typedef struct packed {
    qusmp_chan_s [NUM_CH-1:0] chan;
    logic [1:0]               selSync;
    logic [7:0]               hostData;
    logic                     hostOe;
  } qusmp_state_s;
endpackage

// *** hdl/qusmp_stream_if.sv ***
// Valid/ready byte stream between the block's own modules
`timescale 1ns/1ps
interface qusmp_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// *** hdl/qusmp_fifo.sv ***
// Small registered FIFO for transmit bytes
`timescale 1ns/1ps
module qusmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic     clk,
  input  wire logic     rst_b,
  qusmp_stream_if.snk   inPort,
  qusmp_stream_if.src   outPort
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        inReady;
    logic                        outValid;
  } qusmp_fifo_s;

  qusmp_fifo_s st_ff;
  qusmp_fifo_s nxt_st;

  // Push, pop and registered full/empty flags
  always_comb begin
    logic push;
    logic pop;
    push   = 1'b0;
    pop    = 1'b0;
    nxt_st = st_ff;
    push   = inPort.valid && st_ff.inReady;
    pop    = st_ff.outValid && outPort.ready;
    if (push) begin
      nxt_st.mem[st_ff.wrPtr] = inPort.data;
      nxt_st.wrPtr = AW'(st_ff.wrPtr + 1'b1);
    end
    if (pop) begin
      nxt_st.rdPtr = AW'(st_ff.rdPtr + 1'b1);
    end
    nxt_st.count    = (AW+1)'(st_ff.count + {AW'(0), push} - {AW'(0), pop});
    nxt_st.inReady  = (nxt_st.count != (AW+1)'(DEPTH));
    nxt_st.outValid = (nxt_st.count != '0);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.inReady <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign inPort.ready  = st_ff.inReady;
  assign outPort.valid = st_ff.outValid;
  assign outPort.data  = st_ff.mem[st_ff.rdPtr];
endmodule // qusmp_fifo

// *** hdl/qusmp_top.sv ***
// Four-channel serial, infrared and modem pin logic with status byte
`timescale 1ns/1ps
module qusmp_top
  import qusmp_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          fifoStatusSelectN,
  output wire logic [7:0]                    hostDataOut,
  output wire logic                          hostDataOe,
  input  wire logic [NUM_CH-1:0]             irModeEn,
  input  wire logic [NUM_CH-1:0]             rtsCtl,
  input  wire logic [NUM_CH-1:0]             dtrCtl,
  input  wire logic [NUM_CH-1:0]             autoRtsEn,
  input  wire logic [NUM_CH-1:0]             autoCtsEn,
  input  wire logic [NUM_CH-1:0][DATA_W-1:0] txData,
  input  wire logic [NUM_CH-1:0]             txValid,
  output wire logic [NUM_CH-1:0]             txInReady,
  output wire logic [NUM_CH-1:0][DATA_W-1:0] rxData,
  input  wire logic [NUM_CH-1:0]             rxReadAck,
  output wire logic [NUM_CH-1:0]             serialOut,
  input  wire logic [NUM_CH-1:0]             serialIn,
  output wire logic [NUM_CH-1:0]             infraredOut,
  output wire logic [NUM_CH-1:0]             requestSendN,
  input  wire logic [NUM_CH-1:0]             clearSendN,
  output wire logic [NUM_CH-1:0]             terminalReadyN,
  input  wire logic [NUM_CH-1:0]             setReadyN,
  input  wire logic [NUM_CH-1:0]             carrierPresentN,
  output wire logic [NUM_CH-1:0]             ctsStatusN,
  output wire logic [NUM_CH-1:0]             dsrStatusN,
  output wire logic [NUM_CH-1:0]             cdStatusN,
  output wire logic [NUM_CH-1:0]             txSpaceReadyN,
  output wire logic [NUM_CH-1:0]             rxDataReadyN
);

  qusmp_state_s              st_ff;
  qusmp_state_s              nxt_st;
  logic [NUM_CH-1:0][7:0]    fifoData;
  logic [NUM_CH-1:0]         fifoValid;
  logic [NUM_CH-1:0]         fifoInReady;
  logic [NUM_CH-1:0]         txTake;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    qusmp_stream_if #(.WIDTH(DATA_W)) inIf ();
    qusmp_stream_if #(.WIDTH(DATA_W)) outIf ();

    assign inIf.data      = txData[i];
    assign inIf.valid     = txValid[i];
    assign fifoInReady[i] = inIf.ready;
    assign txInReady[i]   = inIf.ready;
    assign fifoData[i]    = outIf.data;
    assign fifoValid[i]   = outIf.valid;
    assign outIf.ready    = txTake[i];

    qusmp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txFifo (
      .clk     (clk),
      .rst_b   (rst_b),
      .inPort  (inIf),
      .outPort (outIf)
    );

    // Pins straight from channel flops
    assign serialOut[i]      = st_ff.chan[i].serialOut;
    assign infraredOut[i]    = st_ff.chan[i].irOut;
    assign requestSendN[i]   = st_ff.chan[i].requestSendN;
    assign terminalReadyN[i] = st_ff.chan[i].terminalReadyN;
    assign ctsStatusN[i]     = st_ff.chan[i].ctsSync[1];
    assign dsrStatusN[i]     = st_ff.chan[i].dsrSync[1];
    assign cdStatusN[i]      = st_ff.chan[i].cdSync[1];
    assign txSpaceReadyN[i]  = st_ff.chan[i].txSpaceReadyN;
    assign rxDataReadyN[i]   = st_ff.chan[i].rxDataReadyN;
    assign rxData[i]         = st_ff.chan[i].rxHold;
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      txTake[i] = fifoValid[i] && !st_ff.chan[i].txBusy
                  && (!autoCtsEn[i] || !st_ff.chan[i].ctsSync[1]);
    end
  end

  // Channel transmit, receive and handshake logic
  always_comb begin
    logic txBit;
    logic irPulse;
    logic rxLine;
    txBit   = 1'b1;
    irPulse = 1'b0;
    rxLine  = 1'b1;
    nxt_st  = st_ff;
    for (int i = 0; i < NUM_CH; i++) begin
      // Two-stage pin synchronisers
      nxt_st.chan[i].rxSync  = {st_ff.chan[i].rxSync[0], serialIn[i]};
      nxt_st.chan[i].ctsSync = {st_ff.chan[i].ctsSync[0], clearSendN[i]};
      nxt_st.chan[i].dsrSync = {st_ff.chan[i].dsrSync[0], setReadyN[i]};
      nxt_st.chan[i].cdSync  = {st_ff.chan[i].cdSync[0], carrierPresentN[i]};

      // Transmit frame shifter
      if (txTake[i]) begin
        nxt_st.chan[i].txBusy   = 1'b1;
        nxt_st.chan[i].txShift  = {1'b1, fifoData[i], 1'b0};
        nxt_st.chan[i].txBitCnt = 4'h0;
        nxt_st.chan[i].txCyc    = 8'h00;
      end else if (st_ff.chan[i].txBusy) begin
        if (st_ff.chan[i].txCyc == BIT_CYC - 8'h01) begin
          nxt_st.chan[i].txCyc    = 8'h00;
          nxt_st.chan[i].txShift  = {1'b1, st_ff.chan[i].txShift[9:1]};
          nxt_st.chan[i].txBitCnt = st_ff.chan[i].txBitCnt + 4'h1;
          if (st_ff.chan[i].txBitCnt == STOP_IDX) begin
            nxt_st.chan[i].txBusy = 1'b0;
          end
        end else begin
          nxt_st.chan[i].txCyc = st_ff.chan[i].txCyc + 8'h01;
        end
      end
      // Start bit leaves on the take edge, so it lasts a full bit time
      txBit   = nxt_st.chan[i].txBusy ? nxt_st.chan[i].txShift[0] : TX_IDLE;
      irPulse = nxt_st.chan[i].txBusy && !txBit && (nxt_st.chan[i].txCyc < IR_PULSE_CYC);
      nxt_st.chan[i].serialOut = irModeEn[i] ? irPulse : (nxt_st.chan[i].txBusy ? txBit : TX_IDLE);
      nxt_st.chan[i].irOut = irPulse;

      // infrared decoder stretches pulses
      // A plain idle-high line must not leave a stale stretch behind
      // Switching mode while a line is active may still show one false frame
      if (irModeEn[i] && st_ff.chan[i].rxSync[1]) begin
        nxt_st.chan[i].irStretch = BIT_CYC - 8'h01;
      end else if (st_ff.chan[i].irStretch != 8'h00) begin
        nxt_st.chan[i].irStretch = st_ff.chan[i].irStretch - 8'h01;
      end
      rxLine = irModeEn[i] ? (st_ff.chan[i].irStretch == 8'h00 && !st_ff.chan[i].rxSync[1])
                           : st_ff.chan[i].rxSync[1];

      // Receive holding register, ack clears its ready flag
      if (rxReadAck[i]) begin
        nxt_st.chan[i].rxDataReadyN = PIN_OFF_N;
      end
      if (!st_ff.chan[i].rxBusy) begin
        if (!rxLine) begin
          nxt_st.chan[i].rxBusy   = 1'b1;
          nxt_st.chan[i].rxCyc    = RX_HALF_CYC;
          nxt_st.chan[i].rxBitCnt = 4'h0;
        end
      end else if (st_ff.chan[i].rxCyc != 8'h00) begin
        nxt_st.chan[i].rxCyc = st_ff.chan[i].rxCyc - 8'h01;
      end else begin
        nxt_st.chan[i].rxCyc    = BIT_CYC - 8'h01;
        nxt_st.chan[i].rxBitCnt = st_ff.chan[i].rxBitCnt + 4'h1;
        if (st_ff.chan[i].rxBitCnt == 4'h0 && rxLine) begin
          nxt_st.chan[i].rxBusy = 1'b0;  // False start
        end else if (st_ff.chan[i].rxBitCnt == STOP_IDX) begin
          nxt_st.chan[i].rxBusy = 1'b0;
          nxt_st.chan[i].rxHold       = st_ff.chan[i].rxShift;
          nxt_st.chan[i].rxDataReadyN = 1'b0;
        end else if (st_ff.chan[i].rxBitCnt != 4'h0) begin
          nxt_st.chan[i].rxShift = {rxLine, st_ff.chan[i].rxShift[7:1]};
        end
      end

      nxt_st.chan[i].txSpaceReadyN = !fifoInReady[i];
      nxt_st.chan[i].requestSendN = !(rtsCtl[i]
                                      && !(autoRtsEn[i] && !st_ff.chan[i].rxDataReadyN));
      nxt_st.chan[i].terminalReadyN = !dtrCtl[i];
    end

    nxt_st.selSync = {st_ff.selSync[0], fifoStatusSelectN};
    nxt_st.hostOe  = !st_ff.selSync[1];
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_st.hostData[i]          = !st_ff.chan[i].txSpaceReadyN;
      nxt_st.hostData[i + NUM_CH] = st_ff.chan[i].rxDataReadyN;
    end
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff          <= '0;
      st_ff.selSync  <= 2'h3;
      st_ff.hostData <= STATUS_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        st_ff.chan[i].serialOut      <= TX_IDLE;
        st_ff.chan[i].irOut          <= IR_IDLE;
        st_ff.chan[i].rxSync         <= 2'h0;  // Plain line reads as false start
        st_ff.chan[i].ctsSync        <= 2'h3;
        st_ff.chan[i].dsrSync        <= 2'h3;
        st_ff.chan[i].cdSync         <= 2'h3;
        st_ff.chan[i].rxDataReadyN   <= PIN_OFF_N;
        st_ff.chan[i].requestSendN   <= PIN_OFF_N;
        st_ff.chan[i].terminalReadyN <= PIN_OFF_N;
        st_ff.chan[i].txSpaceReadyN  <= PIN_OFF_N;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hostDataOut = st_ff.hostData;
  assign hostDataOe  = st_ff.hostOe;
endmodule // qusmp_top

// *** verif/qusmp_checker.sv ***
// Port assertions for the quad serial modem pin block
`timescale 1ns/1ps
module qusmp_checker
  import qusmp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       fifoStatusSelectN,
  input wire logic [7:0] hostDataOut,
  input wire logic       hostDataOe,
  input wire logic [3:0] irModeEn,
  input wire logic [3:0] rtsCtl,
  input wire logic [3:0] dtrCtl,
  input wire logic [3:0] autoRtsEn,
  input wire logic [3:0] serialOut,
  input wire logic [3:0] infraredOut,
  input wire logic [3:0] requestSendN,
  input wire logic [3:0] terminalReadyN,
  input wire logic [3:0] clearSendN,
  input wire logic [3:0] setReadyN,
  input wire logic [3:0] carrierPresentN,
  input wire logic [3:0] ctsStatusN,
  input wire logic [3:0] dsrStatusN,
  input wire logic [3:0] cdStatusN,
  input wire logic [3:0] txSpaceReadyN,
  input wire logic [3:0] rxDataReadyN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Select runs, one low bit time, one infrared pulse
  sequence s_selLow;
    !fifoStatusSelectN [*4];
  endsequence
  sequence s_selHigh;
    fifoStatusSelectN [*4];
  endsequence
  sequence s_bitLow;
    !serialOut[0] [*8] ##1 !serialOut[0] [*8];
  endsequence
  sequence s_irPulse;
    infraredOut[0] [*3] ##1 !infraredOut[0];
  endsequence
  a_status_drive: assert property (s_selLow |-> hostDataOe)
    else $error("status byte not driven");
  a_status_release: assert property (s_selHigh |-> !hostDataOe)
    else $error("status byte still driven");
  a_status_bits: assert property (hostDataOe |->
    hostDataOut == {$past(rxDataReadyN), ~$past(txSpaceReadyN)})
    else $error("status bits wrong");
  a_bit_time: assert property ($fell(serialOut[0]) && !irModeEn[0] |-> s_bitLow)
    else $error("low run shorter than a bit");
  a_ir_pulse: assert property ($rose(infraredOut[0]) |-> s_irPulse)
    else $error("infrared pulse width wrong");
  a_ir_mirror: assert property ($past(rst_b) |->
    ((serialOut ^ infraredOut) & $past(irModeEn) & $past(irModeEn, 2)) == 4'h0)
    else $error("serial line not encoded");
  a_reset_idle: assert property (!$past(rst_b) |-> serialOut == 4'hF &&
    infraredOut == 4'h0 && requestSendN == 4'hF && terminalReadyN == 4'hF)
    else $error("idle level wrong after reset");
  a_dtr_follow: assert property ($past(rst_b) |-> terminalReadyN == ~$past(dtrCtl))
    else $error("terminal ready wrong");
  a_rts_follow: assert property ($past(rst_b) |->
    (requestSendN | $past(autoRtsEn)) == (~$past(rtsCtl) | $past(autoRtsEn)))
    else $error("request to send wrong");
  a_status_copy: assert property ($past(rst_b) && $past(rst_b, 2) |->
    ctsStatusN == $past(clearSendN, 2) && dsrStatusN == $past(setReadyN, 2) &&
    cdStatusN == $past(carrierPresentN, 2))
    else $error("modem status copy wrong");
endmodule // qusmp_checker

// *** verif/qusmp_partner.sv ***
// Far-end line driver and modem model for four channels
`timescale 1ns/1ps
module qusmp_partner
  import qusmp_pkg::*;
(
  input  wire logic [3:0] irModeEn,
  input  wire logic       clk,
  output wire logic [3:0] serialIn,
  output logic      [3:0] clearSendN,
  output logic      [3:0] setReadyN,
  output logic      [3:0] carrierPresentN
);
  logic [3:0] lineLvl;
  logic [3:0] busy;
  // Quiet lines at time zero
  initial begin
    lineLvl = 4'hF;
    busy = 4'h0;
    clearSendN = 4'hF;
    setReadyN = 4'hF;
    carrierPresentN = 4'hF;
  end
  assign serialIn = (busy & lineLvl) | (~busy & ~irModeEn);
  // Modem line levels
  task automatic set_modem(input logic [3:0] cts, input logic [3:0] dsr, input logic [3:0] cd);
    clearSendN = cts;
    setReadyN = dsr;
    carrierPresentN = cd;
  endtask
  // One frame, plain or pulse encoded
  task automatic send_byte(input int ch, input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    for (int i = 0; i < FRAME_BITS; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk);
        #2 lineLvl[ch] = irModeEn[ch] ? (!frm[i] && c < 3) : frm[i];
        busy[ch] = 1'b1;
      end
    end
    @(posedge clk);
    #2 busy[ch] = 1'b0;
  endtask
endmodule // qusmp_partner

// *** verif/tb.sv ***
// Self-checking bench for the quad serial modem pin block
`timescale 1ns/1ps
module tb;
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  logic            fifoStatusSelectN = 1'b1;
  logic [7:0]      hostDataOut, b;
  logic            hostDataOe;
  logic [3:0]      irModeEn, rtsCtl, dtrCtl, autoRtsEn, autoCtsEn, txValid, rxReadAck;
  logic [3:0]      txInReady, serialOut, serialIn, infraredOut, requestSendN, clearSendN;
  logic [3:0]      terminalReadyN, setReadyN, carrierPresentN, ctsStatusN, dsrStatusN;
  logic [3:0]      cdStatusN, txSpaceReadyN, rxDataReadyN;
  logic [3:0][7:0] txData, rxData;
  logic [7:0]      txQ[$], stQ[$];
  logic [11:0]     rxQ[$];
  int              miscompares = 0, compares = 0, seed = 15584;
  qusmp_top qusmp_top_i (.clk, .rst_b, .fifoStatusSelectN, .hostDataOut, .hostDataOe,
    .irModeEn, .rtsCtl, .dtrCtl, .autoRtsEn, .autoCtsEn, .txData, .txValid, .txInReady,
    .rxData, .rxReadAck, .serialOut, .serialIn, .infraredOut, .requestSendN, .clearSendN,
    .terminalReadyN, .setReadyN, .carrierPresentN, .ctsStatusN, .dsrStatusN, .cdStatusN,
    .txSpaceReadyN, .rxDataReadyN);
  qusmp_partner qusmp_partner_i (.irModeEn, .clk, .serialIn, .clearSendN, .setReadyN,
    .carrierPresentN);
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Offer bytes, note channel A bytes taken
  task automatic push(input int ch, input int n);
    logic ok;
    txValid[ch] = 1'b1;
    txData[ch] = 8'($random(seed));
    repeat (n) begin
      ok = txInReady[ch];
      @(posedge clk);
      if (ok === 1'b1 && ch == 0) txQ.push_back(txData[ch]);
      #2;
      if (ok === 1'b1) txData[ch] = 8'($random(seed));
    end
    txValid[ch] = 1'b0;
  endtask
  task automatic st_read(input logic [7:0] exp);
    stQ.push_back(exp);
    fifoStatusSelectN = 1'b0;
    tick(6);
    fifoStatusSelectN = 1'b1;
    tick(6);
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Decode channel A frames at mid bit
  initial begin : txMon
    logic [7:0] d;
    forever begin
      @(negedge serialOut[0]);
      chk("ctsGate", 12'h0, 12'(ctsStatusN[0] & autoCtsEn[0]));
      repeat (8) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(negedge clk);
        d[i] = serialOut[0];
      end
      repeat (16) @(negedge clk);
      chk("txStop", 12'h1, 12'(serialOut[0]));
      chk("txByte", 12'(txQ.pop_front()), 12'(d));
    end
  end
  // Take received bytes and acknowledge them
  initial begin : rxMon
    forever begin
      @(negedge clk);
      for (int c = 0; c < 4; c++) begin
        if (rxDataReadyN[c] === 1'b0) begin
          chk("rxByte", rxQ.pop_front(), {4'(c), rxData[c]});
          @(posedge clk);
          #2 rxReadAck[c] = 1'b1;
          chk("autoRts", 12'h1, 12'(requestSendN[c]));
          @(posedge clk);
          #2 rxReadAck[c] = 1'b0;
        end
      end
    end
  end
  // Status byte as the bus sees it
  initial begin : stMon
    forever begin
      @(posedge hostDataOe);
      @(negedge clk);
      chk("status", 12'(stQ.pop_front()), 12'(hostDataOut));
    end
  end
  // Hang guard
  initial begin
    #(25 * 20000);
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial begin
    {irModeEn, rtsCtl, dtrCtl, autoRtsEn, autoCtsEn, txValid, rxReadAck} = 28'hC000000;
    txData = 32'h0;
    tick(8);
    rst_b = 1'b1;
    tick(2);
    $display("test reset done");
    repeat (20) begin
      {rtsCtl, dtrCtl} = 8'($random(seed));
      qusmp_partner_i.set_modem(4'hF, 4'($random(seed)), 4'($random(seed)));
      tick(3);
    end
    $display("test modem done");
    autoCtsEn = 4'h1;
    push(0, 10);
    st_read(8'hFE);
    qusmp_partner_i.set_modem(4'h0, 4'($random(seed)), 4'($random(seed)));
    for (int w = 0; w < 1500 && txQ.size() > 0; w++) tick(1);
    chk("txLeft", 12'h0, 12'(txQ.size()));
    st_read(8'hFF);
    $display("test transmit done");
    rtsCtl = 4'h2;
    tick(1);
    autoRtsEn = 4'h2;
    tick(4);
    fork
      push(3, 1);
      for (int c = 1; c < 3; c++) begin
        b = 8'($random(seed));
        rxQ.push_back({4'(c), b});
        qusmp_partner_i.send_byte(c, b);
      end
    join
    for (int w = 0; w < 100 && rxQ.size() > 0; w++) tick(1);
    chk("rxLeft", 12'h0, 12'(rxQ.size()));
    tick(200);
    $display("test receive done");
    complete_run();
  end
endmodule // tb
bind qusmp_top qusmp_checker qusmp_checker_i (.clk, .rst_b, .fifoStatusSelectN,
  .hostDataOut, .hostDataOe, .irModeEn, .rtsCtl, .dtrCtl, .autoRtsEn, .serialOut,
  .infraredOut, .requestSendN, .terminalReadyN, .clearSendN, .setReadyN,
  .carrierPresentN, .ctsStatusN, .dsrStatusN, .cdStatusN, .txSpaceReadyN, .rxDataReadyN);
